// File: sfr_params.svh
// constants of the supply fault response block
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// clock and supervisor sampling period
`define SFR_CLK_PERIOD_NS     50
`define SFR_SAMPLE_PERIOD_NS  12200
`define SFR_TICK_CYCLES       (`SFR_SAMPLE_PERIOD_NS / `SFR_CLK_PERIOD_NS)
`define SFR_TICK_LAST         8'(`SFR_TICK_CYCLES - 1)

// command codes and reset values of the response bytes
`define SFR_CMD_OV_RESP       8'h41
`define SFR_CMD_UV_RESP       8'h45
`define SFR_OV_RESP_RST       8'h80
`define SFR_UV_RESP_RST       8'h7F

// response byte fields
`define SFR_ACT_FIELD         7:6
`define SFR_RETRY_FIELD       5:3
`define SFR_DGL_FIELD         2:0
`define SFR_ACT_RUN           2'h0
`define SFR_ACT_DEGLITCH      2'h1
`define SFR_DGL_MAX           3'h7

// status bit positions
`define SFR_SB_VOUT_OV        5
`define SFR_SB_IOUT_OC        4
`define SFR_SB_OTHER          0
`define SFR_SW_VOUT           15
`define SFR_SW_IOUT           14
`define SFR_SV_OV             7
`define SFR_SV_UV             4
`define SFR_SI_OC             7
`define SFR_SI_UC             4

// retry pause between a faulted shutdown and the restart, in ticks
`define SFR_RETRY_DELAY_TICKS 8'h10

`endif

// File: sfr_pkg.sv
// types and field helpers of the supply fault response block
`include "sfr_params.svh"
package sfr_pkg;

  typedef enum logic [2:0] {
    SFR_ST_OFF,
    SFR_ST_ON,
    SFR_ST_SEQ_OFF,
    SFR_ST_FAULTED,
    SFR_ST_RETRY_WAIT
  } sfr_state_t;

  typedef enum logic {
    SFR_SRC_OV,
    SFR_SRC_UV
  } sfr_src_t;

  // field extraction shared by both fault channels
  function automatic logic [1:0] sfr_action(input logic [7:0] resp);
    sfr_action = resp[`SFR_ACT_FIELD];
  endfunction : sfr_action

  function automatic logic [2:0] sfr_retry(input logic [7:0] resp);
    sfr_retry = resp[`SFR_RETRY_FIELD];
  endfunction : sfr_retry

  function automatic logic [2:0] sfr_dgl(input logic [7:0] resp);
    sfr_dgl = resp[`SFR_DGL_FIELD];
  endfunction : sfr_dgl

endpackage : sfr_pkg

// File: sfr_deglitch.sv
// deglitch and action qualifier for one voltage fault source
`include "sfr_params.svh"

module sfr_deglitch (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       fault_i,
  input  wire logic [7:0] resp_i,
  output logic            trip_o
);

  logic [1:0] act;
  logic [2:0] dgl;
  logic [2:0] cnt_r;

  assign act = sfr_pkg::sfr_action(resp_i);
  assign dgl = sfr_pkg::sfr_dgl(resp_i);

  // samples seen while the fault stands; a gap restarts the count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_r <= 3'h0;
    end else if (!fault_i) begin
      cnt_r <= 3'h0;
    end else if (tick_i && cnt_r != `SFR_DGL_MAX) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  // trip level: ignore, deglitch then act, or act at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trip_o <= 1'b0;
    end else if (act == `SFR_ACT_RUN) begin
      trip_o <= 1'b0;
    end else if (act == `SFR_ACT_DEGLITCH) begin
      trip_o <= fault_i && (cnt_r >= dgl);
    end else begin
      trip_o <= fault_i;
    end
  end

  property p_dgl_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
      (act == `SFR_ACT_DEGLITCH && dgl == 3'h0 && fault_i) |=> trip_o;
  endproperty
  a_dgl_zero: assert property (p_dgl_zero)
    else $error("zero deglitch count did not act at once");

  property p_dgl_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      (act == `SFR_ACT_DEGLITCH && dgl != 3'h0 && cnt_r < dgl) |=> !trip_o;
  endproperty
  a_dgl_hold: assert property (p_dgl_hold)
    else $error("fault acted before its deglitch samples");

endmodule : sfr_deglitch

// File: sfr_top.sv
// per-channel output fault response: status, alert, shutdown, retry
`include "sfr_params.svh"

module sfr_top (
  input  wire logic        SYS_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CMD_WR_I,
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic [7:0]  CMD_DATA_I,
  input  wire logic        CLEAR_FAULTS_I,
  input  wire logic        CONTROL_PIN_I,
  input  wire logic        OPERATION_ON_I,
  input  wire logic        BIAS_OK_I,
  input  wire logic        TRACK_SEQ_OFF_I,
  input  wire logic [7:0]  TOFF_DELAY_I,
  input  wire logic [2:0]  RETRY_COUNT_I,
  input  wire logic        OV_FAULT_I,
  input  wire logic        UV_FAULT_I,
  input  wire logic        OC_FAULT_I,
  input  wire logic        UC_FAULT_I,
  output logic             CHAN_EN_O,
  output logic             FAULT_OFF_O,
  output logic             HOST_NOTIFY_N_O,
  output logic [7:0]       OV_RESP_O,
  output logic [7:0]       UV_RESP_O,
  output logic [7:0]       STATUS_BYTE_O,
  output logic [15:0]      STATUS_WORD_O,
  output logic [7:0]       STATUS_VOUT_O,
  output logic [7:0]       STATUS_IOUT_O
);

  sfr_pkg::sfr_state_t state_r;
  sfr_pkg::sfr_src_t   src_r;
  logic [7:0]          div_r;
  logic                tick_r;
  logic                on_req;
  logic                running;
  logic                ov_trip;
  logic                uv_trip;
  logic [7:0]          wait_r;
  logic [2:0]          retries_r;
  logic                retry_run_r;
  logic [2:0]          ov_retry_r;
  logic [2:0]          uv_retry_r;
  logic [2:0]          src_retry;
  logic [7:0]          sv_set;
  logic [7:0]          si_set;
  logic [7:0]          sb_set;
  logic                any_set;

  // channel asked on only while pin, command and bias all agree
  assign on_req  = CONTROL_PIN_I && OPERATION_ON_I && BIAS_OK_I;
  assign running = (state_r == sfr_pkg::SFR_ST_ON);

  // response byte writes on their command codes
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      OV_RESP_O <= `SFR_OV_RESP_RST;
      UV_RESP_O <= `SFR_UV_RESP_RST;
    end else if (CMD_WR_I) begin
      if (CMD_CODE_I == `SFR_CMD_OV_RESP) begin
        OV_RESP_O <= CMD_DATA_I;
      end
      if (CMD_CODE_I == `SFR_CMD_UV_RESP) begin
        UV_RESP_O <= CMD_DATA_I;
      end
    end
  end

  // supervisor sample tick from a fixed divider of the system clock
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      div_r  <= 8'h00;
      tick_r <= 1'b0;
    end else if (div_r == `SFR_TICK_LAST) begin
      div_r  <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 8'h01;
      tick_r <= 1'b0;
    end
  end

  // faults only count while the channel is up
  sfr_deglitch u_ov_dgl (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (NRST_I),
    .tick_i  (tick_r),
    .fault_i (OV_FAULT_I && running),
    .resp_i  (OV_RESP_O),
    .trip_o  (ov_trip)
  );

  sfr_deglitch u_uv_dgl (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (NRST_I),
    .tick_i  (tick_r),
    .fault_i (UV_FAULT_I && running),
    .resp_i  (UV_RESP_O),
    .trip_o  (uv_trip)
  );

  // retry setting of the source that shut the channel down
  assign src_retry = (src_r == sfr_pkg::SFR_SRC_OV) ? ov_retry_r
                                                    : uv_retry_r;

  // channel sequencer: on, sequenced off, faulted, retry pause
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_r     <= sfr_pkg::SFR_ST_OFF;
      src_r       <= sfr_pkg::SFR_SRC_OV;
      wait_r      <= 8'h00;
      retries_r   <= 3'h0;
      retry_run_r <= 1'b0;
      ov_retry_r  <= 3'h0;
      uv_retry_r  <= 3'h0;
      CHAN_EN_O   <= 1'b0;
      FAULT_OFF_O <= 1'b0;
    end else begin
      case (state_r)
        sfr_pkg::SFR_ST_OFF: begin
          if (on_req) begin
            // retry fields only taken at an off-then-on edge
            ov_retry_r <= sfr_pkg::sfr_retry(OV_RESP_O);
            uv_retry_r <= sfr_pkg::sfr_retry(UV_RESP_O);
            retries_r  <= RETRY_COUNT_I;
            retry_run_r <= 1'b0;
            state_r    <= sfr_pkg::SFR_ST_ON;
            CHAN_EN_O  <= 1'b1;
          end
        end
        sfr_pkg::SFR_ST_ON: begin
          if (!on_req) begin
            state_r   <= sfr_pkg::SFR_ST_OFF;
            CHAN_EN_O <= 1'b0;
          end else if (ov_trip || uv_trip) begin
            src_r <= ov_trip ? sfr_pkg::SFR_SRC_OV : sfr_pkg::SFR_SRC_UV;
            // a different fault ends any retry run in progress
            if (retry_run_r && ov_trip != (src_r == sfr_pkg::SFR_SRC_OV)) begin
              retries_r <= 3'h0;
            end
            wait_r <= 8'h00;
            if (TRACK_SEQ_OFF_I) begin
              state_r <= sfr_pkg::SFR_ST_SEQ_OFF;
            end else begin
              state_r     <= sfr_pkg::SFR_ST_FAULTED;
              CHAN_EN_O   <= 1'b0;
              FAULT_OFF_O <= 1'b1;
            end
          end
        end
        sfr_pkg::SFR_ST_SEQ_OFF: begin
          if (!on_req) begin
            state_r   <= sfr_pkg::SFR_ST_OFF;
            CHAN_EN_O <= 1'b0;
          end else if (wait_r >= TOFF_DELAY_I) begin
            state_r     <= sfr_pkg::SFR_ST_FAULTED;
            CHAN_EN_O   <= 1'b0;
            FAULT_OFF_O <= 1'b1;
          end else if (tick_r) begin
            wait_r <= wait_r + 8'h01;
          end
        end
        sfr_pkg::SFR_ST_FAULTED: begin
          if (!on_req) begin
            state_r     <= sfr_pkg::SFR_ST_OFF;
            FAULT_OFF_O <= 1'b0;
          end else if (src_retry != 3'h0 && retries_r != 3'h0) begin
            state_r <= sfr_pkg::SFR_ST_RETRY_WAIT;
            wait_r  <= 8'h00;
          end
          // retry 000 or count spent: latched until the on request drops
        end
        sfr_pkg::SFR_ST_RETRY_WAIT: begin
          if (!on_req) begin
            state_r     <= sfr_pkg::SFR_ST_OFF;
            FAULT_OFF_O <= 1'b0;
          end else if (wait_r >= `SFR_RETRY_DELAY_TICKS) begin
            state_r     <= sfr_pkg::SFR_ST_ON;
            retries_r   <= retries_r - 3'h1;
            retry_run_r <= 1'b1;
            CHAN_EN_O   <= 1'b1;
            FAULT_OFF_O <= 1'b0;
          end else if (tick_r) begin
            wait_r <= wait_r + 8'h01;
          end
        end
        default: begin
          state_r     <= sfr_pkg::SFR_ST_OFF;
          CHAN_EN_O   <= 1'b0;
          FAULT_OFF_O <= 1'b0;
        end
      endcase
    end
  end

  // status events straight from the fast supervisor comparators
  always_comb begin
    sv_set = 8'h00;
    si_set = 8'h00;
    sb_set = 8'h00;
    sv_set[`SFR_SV_OV] = OV_FAULT_I;
    sv_set[`SFR_SV_UV] = UV_FAULT_I;
    si_set[`SFR_SI_OC] = OC_FAULT_I;
    si_set[`SFR_SI_UC] = UC_FAULT_I;
    sb_set[`SFR_SB_VOUT_OV] = OV_FAULT_I;
    sb_set[`SFR_SB_IOUT_OC] = OC_FAULT_I;
    sb_set[`SFR_SB_OTHER]   = UV_FAULT_I || UC_FAULT_I;
  end
  assign any_set = OV_FAULT_I || UV_FAULT_I || OC_FAULT_I || UC_FAULT_I;

  // sticky status; a fault in the clearing cycle survives the clear
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      STATUS_VOUT_O <= 8'h00;
      STATUS_IOUT_O <= 8'h00;
      STATUS_BYTE_O <= 8'h00;
      STATUS_WORD_O <= 16'h0000;
    end else begin
      STATUS_VOUT_O <= (CLEAR_FAULTS_I ? 8'h00 : STATUS_VOUT_O) | sv_set;
      STATUS_IOUT_O <= (CLEAR_FAULTS_I ? 8'h00 : STATUS_IOUT_O) | si_set;
      STATUS_BYTE_O <= (CLEAR_FAULTS_I ? 8'h00 : STATUS_BYTE_O) | sb_set;
      STATUS_WORD_O[7:0] <= (CLEAR_FAULTS_I ? 8'h00 : STATUS_WORD_O[7:0])
                            | sb_set;
      STATUS_WORD_O[15:8] <= CLEAR_FAULTS_I ? 8'h00 : STATUS_WORD_O[15:8];
      if (OV_FAULT_I || UV_FAULT_I) begin
        STATUS_WORD_O[`SFR_SW_VOUT] <= 1'b1;
      end
      if (OC_FAULT_I || UC_FAULT_I) begin
        STATUS_WORD_O[`SFR_SW_IOUT] <= 1'b1;
      end
    end
  end

  // alert held low until clear; clearing never touches the sequencer
  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      HOST_NOTIFY_N_O <= 1'b1;
    end else if (any_set) begin
      HOST_NOTIFY_N_O <= 1'b0;
    end else if (CLEAR_FAULTS_I) begin
      HOST_NOTIFY_N_O <= 1'b1;
    end
  end

  property p_resp_write;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (CMD_WR_I && CMD_CODE_I == `SFR_CMD_OV_RESP)
        |=> OV_RESP_O == $past(CMD_DATA_I);
  endproperty
  a_resp_write: assert property (p_resp_write)
    else $error("overvoltage response byte not written");

  property p_run_on;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (running && on_req
       && sfr_pkg::sfr_action(OV_RESP_O) == `SFR_ACT_RUN
       && sfr_pkg::sfr_action(UV_RESP_O) == `SFR_ACT_RUN) |=> CHAN_EN_O;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("channel dropped while faults are ignored");

  property p_fast_off;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (running && on_req && !TRACK_SEQ_OFF_I && ov_trip)
        |=> !CHAN_EN_O && FAULT_OFF_O;
  endproperty
  a_fast_off: assert property (p_fast_off)
    else $error("tripped channel not shut down at once");

  property p_seq_off;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (running && on_req && TRACK_SEQ_OFF_I && (ov_trip || uv_trip))
        |=> CHAN_EN_O && state_r == sfr_pkg::SFR_ST_SEQ_OFF;
  endproperty
  a_seq_off: assert property (p_seq_off)
    else $error("sequenced shutdown did not hold the channel on");

  property p_no_retry;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (state_r == sfr_pkg::SFR_ST_FAULTED && on_req && src_retry == 3'h0)
        |=> state_r == sfr_pkg::SFR_ST_FAULTED && !CHAN_EN_O;
  endproperty
  a_no_retry: assert property (p_no_retry)
    else $error("channel left fault-off without retry");

  property p_latch_clear;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (FAULT_OFF_O && !on_req) |=> !FAULT_OFF_O ##1 !FAULT_OFF_O;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("off request did not clear the fault latch");

  property p_clear_keeps_off;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      (CLEAR_FAULTS_I && !any_set && on_req
       && state_r == sfr_pkg::SFR_ST_FAULTED && src_retry == 3'h0)
        |=> HOST_NOTIFY_N_O && STATUS_IOUT_O == 8'h00 && FAULT_OFF_O;
  endproperty
  a_clear_keeps_off: assert property (p_clear_keeps_off)
    else $error("clear faults wrong on alert, status or latch");

  property p_oc_alert;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      OC_FAULT_I |=> STATUS_IOUT_O[`SFR_SI_OC]
        && STATUS_WORD_O[`SFR_SW_IOUT] && !HOST_NOTIFY_N_O;
  endproperty
  a_oc_alert: assert property (p_oc_alert)
    else $error("overcurrent did not set status and alert");

  property p_tick_gap;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
      tick_r |=> !tick_r [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("sample tick repeated too soon");

endmodule : sfr_top

// File: sfr_supply_model.sv
// managed supply channel model that raises fast supervisor faults
module sfr_supply_model (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [3:0] inject_i,
  output logic      [3:0] fault_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a disabled output is not regulated, so its faults vanish with it
  always_ff @(posedge clk_i) begin
    fault_o <= en_i ? inject_i : 4'h0;
  end
endmodule : sfr_supply_model

// File: test_sfr_top.sv
// self-checking bench of the supply fault response block
module test_sfr_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk = 1'b0;
  logic        nrst_n = 1'b0;
  logic        wr = 1'b0;
  logic [7:0]  code = 8'h00;
  logic [7:0]  data = 8'h00;
  logic        clr = 1'b0;
  logic        ctl = 1'b0;
  logic        op = 1'b1;
  logic        bias = 1'b1;
  logic        track = 1'b0;
  logic [7:0]  toff = 8'h02;
  logic [2:0]  rcnt = 3'h0;
  logic [3:0]  inj = 4'h0;
  logic [3:0]  flt;
  logic        en, foff, ntf_n;
  logic [7:0]  ovr, uvr, sb, sv, si;
  logic [15:0] sw;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #25 sys_clk = ~sys_clk;

  sfr_supply_model model (.clk_i(sys_clk), .en_i(en), .inject_i(inj),
    .fault_o(flt));

  sfr_top dut (.SYS_CLK_I(sys_clk), .NRST_I(nrst_n), .CMD_WR_I(wr),
    .CMD_CODE_I(code), .CMD_DATA_I(data), .CLEAR_FAULTS_I(clr),
    .CONTROL_PIN_I(ctl), .OPERATION_ON_I(op), .BIAS_OK_I(bias),
    .TRACK_SEQ_OFF_I(track), .TOFF_DELAY_I(toff), .RETRY_COUNT_I(rcnt),
    .OV_FAULT_I(flt[0]), .UV_FAULT_I(flt[1]), .OC_FAULT_I(flt[2]),
    .UC_FAULT_I(flt[3]), .CHAN_EN_O(en), .FAULT_OFF_O(foff),
    .HOST_NOTIFY_N_O(ntf_n), .OV_RESP_O(ovr), .UV_RESP_O(uvr),
    .STATUS_BYTE_O(sb), .STATUS_WORD_O(sw), .STATUS_VOUT_O(sv),
    .STATUS_IOUT_O(si));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // a hung wait must not stall the run forever
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (e !== g) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // outputs are looked at on the falling edge, well settled
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  task automatic wr_byte(input logic [7:0] c, d);
    @(posedge sys_clk);
    wr <= 1'b1;
    code <= c;
    data <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
    cyc(1);
  endtask : wr_byte

  task automatic clear();
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    cyc(2);
  endtask : clear

  task automatic wait_en(input logic v, input int lim);
    int n;
    n = 0;
    while (en !== v && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    chk("chan_en", {15'h0, v}, {15'h0, en});
  endtask : wait_en

  task automatic set_inj(input logic [3:0] v);
    @(posedge sys_clk);
    inj <= v;
    cyc(3);
  endtask : set_inj

  // host toggles the control pin to clear a latch and restart
  task automatic recycle();
    set_inj(4'h0);
    @(posedge sys_clk);
    ctl <= 1'b0;
    cyc(3);
    chk("fault_off", 16'h0, {15'h0, foff});
    clear();
    @(posedge sys_clk);
    ctl <= 1'b1;
    wait_en(1'b1, 5);
  endtask : recycle

  // a fault that must shut the channel two edges after the supervisor
  task automatic quick_off(input logic [7:0] c, d, input logic [3:0] v);
    wr_byte(c, d);
    set_inj(v);
    cyc(1);
    chk("chan_en", 16'h0, {15'h0, en});
    chk("fault_off", 16'h1, {15'h0, foff});
    set_inj(4'h0);
  endtask : quick_off

  task automatic chk_stat(input logic [15:0] w, input logic [7:0] v, i);
    chk("status_word", w, sw);
    chk("status_byte", {8'h00, w[7:0]}, {8'h00, sb});
    chk("status_vout", {8'h00, v}, {8'h00, sv});
    chk("status_iout", {8'h00, i}, {8'h00, si});
    chk("notify_n", {15'h0, ~|w}, {15'h0, ntf_n});
  endtask : chk_stat

  initial begin
    cyc(3);
    @(posedge sys_clk);
    nrst_n <= 1'b1;
    cyc(1);
    chk("ov_resp", 16'h0080, {8'h00, ovr});
    chk("uv_resp", 16'h007F, {8'h00, uvr});
    chk_stat(16'h0000, 8'h00, 8'h00);
    wr_byte(8'h47, 8'h55);
    chk("ov_resp", 16'h0080, {8'h00, ovr});
    wr_byte(8'h41, 8'h00);
    wr_byte(8'h45, 8'h00);
    chk("uv_resp", 16'h0000, {8'h00, uvr});
    @(posedge sys_clk);
    ctl <= 1'b1;
    wait_en(1'b1, 5);
    set_inj(4'h1);
    cyc(20);
    chk("chan_en", 16'h1, {15'h0, en});
    chk_stat(16'h8020, 8'h80, 8'h00);
    clear();
    chk("notify_n", 16'h0, {15'h0, ntf_n});
    set_inj(4'h2);
    chk_stat(16'h8021, 8'h90, 8'h00);
    set_inj(4'h0);
    clear();
    chk_stat(16'h0000, 8'h00, 8'h00);
    set_inj(4'h4);
    chk_stat(16'h4010, 8'h00, 8'h80);
    set_inj(4'h8);
    chk_stat(16'h4011, 8'h00, 8'h90);
    chk("chan_en", 16'h1, {15'h0, en});
    set_inj(4'h0);
    clear();
    wr_byte(8'h41, 8'h80);
    set_inj(4'h1);
    cyc(1);
    chk("chan_en", 16'h0, {15'h0, en});
    chk("fault_off", 16'h1, {15'h0, foff});
    clear();
    chk_stat(16'h0000, 8'h00, 8'h00);
    chk("fault_off", 16'h1, {15'h0, foff});
    cyc(4300);
    chk("chan_en", 16'h0, {15'h0, en});
    recycle();
    wr_byte(8'h45, 8'h43);
    set_inj(4'h2);
    cyc(400);
    chk("chan_en", 16'h1, {15'h0, en});
    wait_en(1'b0, 400);
    recycle();
    quick_off(8'h45, 8'hC0, 4'h2);
    @(posedge sys_clk);
    bias <= 1'b0;
    cyc(3);
    chk("fault_off", 16'h0, {15'h0, foff});
    @(posedge sys_clk);
    bias <= 1'b1;
    wait_en(1'b1, 5);
    quick_off(8'h41, 8'h40, 4'h1);
    @(posedge sys_clk);
    op <= 1'b0;
    cyc(3);
    chk("fault_off", 16'h0, {15'h0, foff});
    @(posedge sys_clk);
    op <= 1'b1;
    wait_en(1'b1, 5);
    @(posedge sys_clk);
    track <= 1'b1;
    set_inj(4'h1);
    cyc(200);
    chk("chan_en", 16'h1, {15'h0, en});
    wait_en(1'b0, 600);
    @(posedge sys_clk);
    track <= 1'b0;
    rcnt <= 3'h1;
    wr_byte(8'h41, 8'h88);
    recycle();
    set_inj(4'h1);
    wait_en(1'b0, 5);
    wait_en(1'b1, 4200);
    wait_en(1'b0, 5);
    cyc(4400);
    chk("chan_en", 16'h0, {15'h0, en});
    give_verdict();
  end
endmodule : test_sfr_top
